// file: ccd_pkg.sv
// Purpose: Shared constants for the card detect and signal gating block.
// Assumes: System clock of 200 MHz; one 8-bit command and feedback word.
// Notes: Field positions of both words and the filter and ramp timing counts live here.
package ccd_pkg;
  // Width of the serial command and feedback words.
  localparam int WORD_W = 8;
  // Command word fields.
  localparam int CMD_POL = 0;
  localparam int CMD_MODE = 1;
  localparam int CMD_ACT = 2;
  // Feedback word fields.
  localparam int FB_ACT = 0;
  localparam int FB_RAMP = 1;
  localparam int FB_DET = 4;
  // Synchroniser lanes, their count and their reset levels.
  localparam int SI_DET = 0;
  localparam int SI_RST = 1;
  localparam int SI_CS = 2;
  localparam int SI_HIO = 3;
  localparam int SI_CIO = 4;
  localparam int SI_N = 5;
  localparam logic [SI_N-1:0] SI_RST_VAL = 5'h1d;
  // Clock period and times in their own units.
  localparam int CLK_PERIOD_NS = 5;
  localparam int FILT_TIME_NS = 1000;
  localparam int RAMP_TIME_NS = 50000;
  // Least times round up to whole cycles.
  localparam int FILT_CYC = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAMP_CYC = (RAMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  // Reset values of the host-written settings.
  localparam logic RST_POL = 1'h0;
  localparam logic RST_MODE = 1'h0;
  // Card power state, binary coded.
  typedef enum logic [1:0] {
    CCD_OFF = 2'h0,
    CCD_RAMP = 2'h1,
    CCD_ON = 2'h2
  } ccd_card_e;
endpackage : ccd_pkg

// file: ccd_link_if.sv
// Purpose: Carries command and feedback words between link and core.
// Assumes: The command word is stable whenever the toggle has flipped.
// Notes: The link side writes cmd and cmd_tgl; the core writes status.
`timescale 1ns/100ps
interface ccd_link_if;
  // Last complete command word, held in the link clock domain.
  logic [ccd_pkg::WORD_W-1:0] cmd;
  // Flips once per completed command word.
  logic cmd_tgl;
  // Feedback word, held in the system clock domain.
  logic [ccd_pkg::WORD_W-1:0] status;
  modport link (output cmd, output cmd_tgl, input status);
  modport core (input cmd, input cmd_tgl, output status);
endinterface : ccd_link_if

// file: ccd_det_filter.sv
// Purpose: Digital spike filter for the synchronised card presence level.
// Assumes: The input has already passed a two flip-flop synchroniser.
// Notes: The output only follows a level that stays put for FILT_CYC cycles.
`timescale 1ns/100ps
module ccd_det_filter (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_level,
  output logic o_level
);
  // All state of the filter.
  typedef struct packed {
    logic filt_r;
    logic [ccd_pkg::CNT_W-1:0] cnt_r;
  } ccd_filt_s;

  ccd_filt_s r;
  ccd_filt_s r_nxt;

  // Count how long the input has differed from the output; a spike restarts it.
  always_comb begin
    r_nxt = r;
    if (i_level == r.filt_r) begin
      r_nxt.cnt_r = '0;
    end else if (r.cnt_r == ccd_pkg::CNT_W'(ccd_pkg::FILT_CYC - 1)) begin
      r_nxt.filt_r = i_level;
      r_nxt.cnt_r = '0;
    end else begin
      r_nxt.cnt_r = r.cnt_r + 1'b1;
    end
  end

  // Undriven pin idles high, so the filter starts from the high level.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r.filt_r <= 1'b1;
      r.cnt_r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign o_level = r.filt_r;

  // A change at the output needs the full count of differing cycles.
  property p_filt_change;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (r.filt_r != $past(r.filt_r)) |->
      ($past(r.cnt_r) == ccd_pkg::CNT_W'(ccd_pkg::FILT_CYC - 1));
  endproperty
  a_filt_change: assert property (p_filt_change) else $error("Filter moved early.");

  // A one-cycle spike never reaches the output.
  property p_filt_spike;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (i_level != r.filt_r) ##1 (i_level == r.filt_r) |=> $stable(r.filt_r);
  endproperty
  a_filt_spike: assert property (p_filt_spike) else $error("Spike passed filter.");
endmodule : ccd_det_filter

// file: ccd_spi_link.sv
// Purpose: Serial command and feedback shifter on the link clock.
// Assumes: Link clock runs only inside a frame; select is low in a frame.
// Notes: Eight bits per frame, most significant first, sampled on rising edge.
`timescale 1ns/100ps
module ccd_spi_link (
  input wire logic i_spi_clk,
  input wire logic i_rstn,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  output logic o_miso,
  ccd_link_if.link lk
);
  localparam int W = ccd_pkg::WORD_W;

  // State kept across frames, cleared only by the system reset.
  typedef struct packed {
    logic [W-1:0] st_s1_r;
    logic [W-1:0] st_s2_r;
    logic [W-1:0] hold_r;
    logic tgl_r;
  } ccd_keep_s;

  // State of the current frame, cleared whenever select goes high.
  typedef struct packed {
    logic [2:0] bit_r;
    logic [W-1:0] rx_r;
    logic [W-1:0] tx_r;
  } ccd_frame_s;

  ccd_keep_s k;
  ccd_keep_s k_nxt;
  ccd_frame_s f;
  ccd_frame_s f_nxt;
  logic frame_rstn;

  // The clock stops between frames, so the frame state is cleared by select itself.
  assign frame_rstn = i_rstn & ~i_cs_n;

  // Shift in the command, shift out the feedback, publish each full word.
  always_comb begin
    k_nxt = k;
    f_nxt = f;
    k_nxt.st_s1_r = lk.status;
    k_nxt.st_s2_r = k.st_s1_r;
    f_nxt.rx_r = {f.rx_r[W-2:0], i_mosi};
    f_nxt.bit_r = f.bit_r + 1'b1;
    if (f.bit_r == 3'h0) begin
      f_nxt.tx_r = {k.st_s2_r[W-2:0], 1'b0};
    end else begin
      f_nxt.tx_r = {f.tx_r[W-2:0], 1'b0};
    end
    if (f.bit_r == 3'h7) begin
      k_nxt.hold_r = {f.rx_r[W-2:0], i_mosi};
      k_nxt.tgl_r = ~k.tgl_r;
    end
  end

  // Cross-frame state.
  always_ff @(posedge i_spi_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      k <= '0;
    end else begin
      k <= k_nxt;
    end
  end

  // Per-frame state.
  always_ff @(posedge i_spi_clk or negedge frame_rstn) begin
    if (!frame_rstn) begin
      f <= '0;
    end else begin
      f <= f_nxt;
    end
  end

  // First bit comes straight from the synchronised status before any edge.
  assign o_miso = (f.bit_r == 3'h0) ? k.st_s2_r[W-1] : f.tx_r[W-1];
  assign lk.cmd = k.hold_r;
  assign lk.cmd_tgl = k.tgl_r;
endmodule : ccd_spi_link

// file: ccd_top.sv
// Purpose: Card presence reporting and card reset and serial line gating.
// Assumes: Pins are asynchronous to i_sys_clk; serial link has its own clock.
// Notes: Serial lines are open-drain style: value, enable, input; reset is a plain output.
// Overview of operation
// - Filter spikes on the card presence input.
// - Undriven presence input reads high.
// - Host-written polarity decides which level is presence.
// - Normal mode: bit four high when inserted.
// - Special mode: bit four copies filtered level.
// - Forward host reset only while select low.
// - Drive card reset low when deactivated.
// - Relay serial line both ways while active.
// - Force serial line low in ramp and off.
`timescale 1ns/100ps
module ccd_top #(
  parameter int RAMP_CYCLES = ccd_pkg::RAMP_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_spi_clk,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  input wire logic i_host_reset,
  input wire logic i_host_io,
  output logic o_host_io,
  output logic o_host_io_oe,
  input wire logic i_card_presence_input,
  output logic o_card_presence_pullup_en,
  output logic o_card_reset_output,
  input wire logic i_card_serial_line,
  output logic o_card_serial_line,
  output logic o_card_serial_line_oe,
  output logic o_card_supply_en,
  output logic o_card_present
);
  localparam int W = ccd_pkg::WORD_W;
  localparam int N = ccd_pkg::SI_N;
  // Cycles during which a released line may still echo the core's own low:
  // one output register and two synchroniser stages.
  localparam int ECHO_N = 3;

  // All state of the core, in the system clock domain.
  typedef struct packed {
    logic [N-1:0] s1_r;
    logic [N-1:0] s2_r;
    logic [2:0] tgl_r;
    logic pol_r;
    logic mode_r;
    logic act_r;
    ccd_pkg::ccd_card_e state_r;
    logic [ccd_pkg::CNT_W-1:0] cnt_r;
    logic rst_r;
    logic drv_card_r;
    logic drv_host_r;
    logic [ECHO_N-1:0] ech_card_r;
    logic [ECHO_N-1:0] ech_host_r;
    logic [W-1:0] status_r;
  } ccd_core_s;

  ccd_core_s r;
  ccd_core_s r_nxt;

  // Words between the link shifter and this core.
  ccd_link_if lk ();

  // Filtered presence level.
  logic filt;
  // Card present after polarity decode.
  logic present;
  // A new command word has arrived this cycle.
  logic cmd_evt;
  // A side is busy while the core drives it or while its own low may still echo.
  logic card_busy;
  logic host_busy;

  // Polarity low means a low level is a card; high means a high level is.
  function automatic logic ccd_decode(input logic level, input logic pol);
    ccd_decode = (level == pol);
  endfunction : ccd_decode

  // Serial command link on its own clock.
  ccd_spi_link u_link (
    .i_spi_clk(i_spi_clk),
    .i_rstn(i_rstn),
    .i_cs_n(i_spi_cs_n),
    .i_mosi(i_spi_mosi),
    .o_miso(o_spi_miso),
    .lk(lk.link)
  );

  // Spike filter, fed from the second synchroniser stage only.
  ccd_det_filter u_filt (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_level(r.s2_r[ccd_pkg::SI_DET]),
    .o_level(filt)
  );

  assign present = ccd_decode(filt, r.pol_r);
  // Toggle edge seen between stages two and three, never on stage one.
  assign cmd_evt = r.tgl_r[1] ^ r.tgl_r[2];
  // Without the echo guard the two sides would hand a low back and forth forever.
  assign card_busy = r.drv_card_r | (|r.ech_card_r);
  assign host_busy = r.drv_host_r | (|r.ech_host_r);

  // Next-state logic of the whole core.
  always_comb begin
    r_nxt = r;
    // Pin synchronisers; stage one feeds stage two only.
    r_nxt.s1_r = {i_card_serial_line, i_host_io, i_spi_cs_n,
                  i_host_reset, i_card_presence_input};
    r_nxt.s2_r = r.s1_r;
    r_nxt.tgl_r = {r.tgl_r[1:0], lk.cmd_tgl};
    // Command word is stable for a whole frame after the toggle flips.
    if (cmd_evt) begin
      r_nxt.pol_r = lk.cmd[ccd_pkg::CMD_POL];
      r_nxt.mode_r = lk.cmd[ccd_pkg::CMD_MODE];
      r_nxt.act_r = lk.cmd[ccd_pkg::CMD_ACT];
    end
    // Card power sequence.
    unique case (r.state_r)
      ccd_pkg::CCD_OFF: begin
        r_nxt.cnt_r = '0;
        if (r.act_r && present) begin
          r_nxt.state_r = ccd_pkg::CCD_RAMP;
        end
      end
      ccd_pkg::CCD_RAMP: begin
        // Removal or a deactivate command aborts the ramp.
        if (!r.act_r || !present) begin
          r_nxt.state_r = ccd_pkg::CCD_OFF;
        end else if (r.cnt_r == ccd_pkg::CNT_W'(RAMP_CYCLES - 1)) begin
          r_nxt.state_r = ccd_pkg::CCD_ON;
          r_nxt.cnt_r = '0;
        end else begin
          r_nxt.cnt_r = r.cnt_r + 1'b1;
        end
      end
      ccd_pkg::CCD_ON: begin
        // Pulling a card out drops it straight to off for safety.
        if (!r.act_r || !present) begin
          r_nxt.state_r = ccd_pkg::CCD_OFF;
        end
      end
      default: begin
        // The spare code is illegal; recover to off.
        r_nxt.state_r = ccd_pkg::CCD_OFF;
      end
    endcase
    // Card reset output.
    if (r.state_r != ccd_pkg::CCD_ON) begin
      r_nxt.rst_r = 1'b0;
    end else if (!r.s2_r[ccd_pkg::SI_CS]) begin
      r_nxt.rst_r = r.s2_r[ccd_pkg::SI_RST];
    end
    // Serial relay; the side that pulled low first owns the line, and a low
    // that is only the echo of the core's own drive is ignored.
    r_nxt.ech_card_r = {r.ech_card_r[ECHO_N-2:0], r.drv_card_r};
    r_nxt.ech_host_r = {r.ech_host_r[ECHO_N-2:0], r.drv_host_r};
    if (r.state_r != ccd_pkg::CCD_ON) begin
      r_nxt.drv_card_r = 1'b1;
      r_nxt.drv_host_r = 1'b0;
    end else begin
      r_nxt.drv_card_r = !r.s2_r[ccd_pkg::SI_HIO] && !host_busy;
      // A tie goes to the host side, so both drivers never start together.
      r_nxt.drv_host_r = !r.s2_r[ccd_pkg::SI_CIO] && !card_busy && !r_nxt.drv_card_r;
    end
    // Feedback word.
    r_nxt.status_r = '0;
    r_nxt.status_r[ccd_pkg::FB_DET] = r.mode_r ? filt : present;
    r_nxt.status_r[ccd_pkg::FB_ACT] = (r.state_r == ccd_pkg::CCD_ON);
    r_nxt.status_r[ccd_pkg::FB_RAMP] = (r.state_r == ccd_pkg::CCD_RAMP);
  end

  // State register; synchronisers reset to the idle pin levels.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r.s1_r <= ccd_pkg::SI_RST_VAL;
      r.s2_r <= ccd_pkg::SI_RST_VAL;
      r.tgl_r <= '0;
      r.pol_r <= ccd_pkg::RST_POL;
      r.mode_r <= ccd_pkg::RST_MODE;
      r.act_r <= 1'b0;
      r.state_r <= ccd_pkg::CCD_OFF;
      r.cnt_r <= '0;
      r.rst_r <= 1'b0;
      r.drv_card_r <= 1'b1;
      r.drv_host_r <= 1'b0;
      r.ech_card_r <= '1;
      r.ech_host_r <= '0;
      r.status_r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  // Pins; both lines are open-drain so only a low is ever driven.
  assign lk.status = r.status_r;
  assign o_card_presence_pullup_en = 1'b1;
  assign o_card_reset_output = r.rst_r;
  assign o_card_serial_line = 1'b0;
  assign o_card_serial_line_oe = r.drv_card_r;
  assign o_host_io = 1'b0;
  assign o_host_io_oe = r.drv_host_r;
  assign o_card_supply_en = (r.state_r != ccd_pkg::CCD_OFF);
  assign o_card_present = present;

  // Pull-up stays on from reset onward.
  property p_pullup;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    o_card_presence_pullup_en;
  endproperty
  a_pullup: assert property (p_pullup) else $error("Pull-up dropped.");

  // Polarity and mode follow each new command word.
  property p_cmd_load;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    cmd_evt |=> (r.pol_r == $past(lk.cmd[ccd_pkg::CMD_POL]))
      && (r.mode_r == $past(lk.cmd[ccd_pkg::CMD_MODE]));
  endproperty
  a_cmd_load: assert property (p_cmd_load) else $error("Command not taken.");

  // Normal mode reports insertion whatever the polarity.
  property p_norm;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    !r.mode_r |=> (r.status_r[ccd_pkg::FB_DET] == ccd_decode($past(filt), $past(r.pol_r)));
  endproperty
  a_norm: assert property (p_norm) else $error("Normal report wrong.");

  // Special mode copies the filtered level.
  property p_spec;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    r.mode_r |=> (r.status_r[ccd_pkg::FB_DET] == $past(filt));
  endproperty
  a_spec: assert property (p_spec) else $error("Special report wrong.");

  // Host reset passes while selected, and holds while deselected.
  property p_rst_pass;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (r.state_r == ccd_pkg::CCD_ON) && !r.s2_r[ccd_pkg::SI_CS]
      |=> (o_card_reset_output == $past(r.s2_r[ccd_pkg::SI_RST]));
  endproperty
  a_rst_pass: assert property (p_rst_pass) else $error("Reset not forwarded.");

  property p_rst_hold;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (r.state_r == ccd_pkg::CCD_ON) && r.s2_r[ccd_pkg::SI_CS] |=> $stable(o_card_reset_output);
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("Reset moved unselected.");

  // Off or ramping forces reset and serial line low one cycle later.
  property p_off_low;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (r.state_r != ccd_pkg::CCD_ON)
      |=> !o_card_reset_output && o_card_serial_line_oe && !o_card_serial_line;
  endproperty
  a_off_low: assert property (p_off_low) else $error("Lines not forced low.");

  // A host low reaches the card within one cycle unless the card owns the line.
  property p_relay;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (r.state_r == ccd_pkg::CCD_ON) && !r.s2_r[ccd_pkg::SI_HIO] && !host_busy
      |=> o_card_serial_line_oe;
  endproperty
  a_relay: assert property (p_relay) else $error("Serial relay missed.");

  // A card low reaches the host side when the host side is quiet.
  property p_relay_back;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (r.state_r == ccd_pkg::CCD_ON) && !r.s2_r[ccd_pkg::SI_CIO] && !card_busy
      && r.s2_r[ccd_pkg::SI_HIO] |=> o_host_io_oe;
  endproperty
  a_relay_back: assert property (p_relay_back) else $error("Card low not relayed.");

  // The two relay drivers are never on together.
  property p_one_owner;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    !(o_card_serial_line_oe && o_host_io_oe);
  endproperty
  a_one_owner: assert property (p_one_owner) else $error("Both relay sides driven.");

  // Throughout the ramp the supply is on and the serial line is held low.
  property p_ramp_low;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (r.state_r == ccd_pkg::CCD_RAMP) |-> o_card_supply_en && o_card_serial_line_oe;
  endproperty
  a_ramp_low: assert property (p_ramp_low) else $error("Line free during ramp.");

  // The ramp lasts its full count before the card goes active.
  property p_ramp_len;
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (r.state_r == ccd_pkg::CCD_ON) && ($past(r.state_r) == ccd_pkg::CCD_RAMP)
      |-> ($past(r.cnt_r) == ccd_pkg::CNT_W'(RAMP_CYCLES - 1));
  endproperty
  a_ramp_len: assert property (p_ramp_len) else $error("Ramp cut short.");

  // Main scenarios.
  c_insert: cover property (@(posedge i_sys_clk) disable iff (!i_rstn) $rose(present));
  c_active: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
    $rose(r.state_r == ccd_pkg::CCD_ON));
  c_special: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
    r.mode_r && r.status_r[ccd_pkg::FB_DET]);
  c_relay: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
    $rose(o_host_io_oe));
  c_rst_fwd: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
    $rose(o_card_reset_output));
endmodule : ccd_top

// file: ccd_host_model.sv
// Purpose: Host model that frames command words on the serial link.
// Assumes: The link clock idles low and runs only inside a frame.
// Notes: The bench calls the tasks; one frame carries one whole word.
`timescale 1ns/100ps
module ccd_host_model (
  output logic o_spi_clk,
  output logic o_spi_cs_n,
  output logic o_spi_mosi,
  input wire logic i_spi_miso
);
  // Idle levels before the first frame.
  initial begin
    o_spi_clk = 1'b0;
    o_spi_cs_n = 1'b1;
    o_spi_mosi = 1'b1;
  end

  // Shifts one word out, most significant bit first, with a 30 ns clock.
  // Feedback is taken just before each rising edge, where it has settled.
  task automatic xfer(input logic [7:0] cmd, output logic [7:0] fb);
    #7;
    o_spi_cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      o_spi_mosi = cmd[i];
      #15;
      fb[i] = i_spi_miso;
      o_spi_clk = 1'b1;
      #15;
      o_spi_clk = 1'b0;
    end
    #15;
    o_spi_cs_n = 1'b1;
    // The data line is flipped once released, so no stale bit looks held.
    o_spi_mosi = ~o_spi_mosi;
    // The gap keeps word ends well over four system clocks apart.
    #60;
  endtask : xfer

  // Moves the select line without running the link clock.
  task automatic select(input logic lvl);
    o_spi_cs_n = lvl;
  endtask : select
endmodule : ccd_host_model

// file: ccd_top_tb_top.sv
// Purpose: Self-checking bench for presence reporting and card line gating.
// Assumes: Ramp shortened through the parameter; filter keeps 200 cycles.
// Notes: Wires with pull-ups are resolved here from every party's enable.
`timescale 1ns/100ps
module ccd_top_tb_top;
  // Ramp long enough to look at the ramp state after a frame ends.
  localparam int RAMP = 60;
  logic clk, rstn, spi_clk, cs_n, mosi, miso;
  logic host_rst, host_low, card_low, pin_drv, pin_val;
  logic host_io_oe, card_oe, pull_en, card_rst, supply_en, present;
  logic host_io_o, card_io_o;
  logic [7:0] fb;
  int bad_count;
  int compares;

  // System clock of 200 MHz.
  always #2.5 clk = ~clk;

  ccd_top #(.RAMP_CYCLES(RAMP)) ccd_top_inst (
    .i_sys_clk(clk),
    .i_rstn(rstn),
    .i_spi_clk(spi_clk),
    .i_spi_cs_n(cs_n),
    .i_spi_mosi(mosi),
    .o_spi_miso(miso),
    .i_host_reset(host_rst),
    .i_host_io(~(host_io_oe | host_low)),
    .o_host_io(host_io_o),
    .o_host_io_oe(host_io_oe),
    .i_card_presence_input(pin_drv ? pin_val : pull_en),
    .o_card_presence_pullup_en(pull_en),
    .o_card_reset_output(card_rst),
    .i_card_serial_line(~(card_oe | card_low)),
    .o_card_serial_line(card_io_o),
    .o_card_serial_line_oe(card_oe),
    .o_card_supply_en(supply_en),
    .o_card_present(present)
  );

  ccd_host_model ccd_host_model_inst (
    .o_spi_clk(spi_clk),
    .o_spi_cs_n(cs_n),
    .o_spi_mosi(mosi),
    .i_spi_miso(miso)
  );

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Waits whole cycles and lands on a falling edge, where inputs change.
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Feedback may trail by one frame, so the third frame is the one kept.
  task automatic rd(input logic [7:0] cmd);
    ccd_host_model_inst.xfer(cmd, fb);
    cyc(20);
    ccd_host_model_inst.xfer(cmd, fb);
    ccd_host_model_inst.xfer(cmd, fb);
    cyc(1);
  endtask : rd

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // The tests take some 13 us; over seven times that means a hang.
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end

  // Main sequence.
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    host_rst = 1'b0;
    host_low = 1'b0;
    card_low = 1'b0;
    pin_drv = 1'b0;
    pin_val = 1'b1;
    bad_count = 0;
    compares = 0;
    cyc(2);
    rstn = 1'b1;
    cyc(2);
    chk({6'h00, card_rst, card_oe}, 8'h01);
    chk({7'h00, pull_en}, 8'h01);
    // A low pulse shorter than the filter span must not count.
    pin_drv = 1'b1;
    pin_val = 1'b0;
    cyc(150);
    pin_val = 1'b1;
    cyc(250);
    chk({7'h00, present}, 8'h00);
    pin_val = 1'b0;
    cyc(250);
    chk({7'h00, present}, 8'h01);
    // Low switch with low-active polarity, in both reporting modes.
    rd(8'h00);
    chk(fb & 8'h10, 8'h10);
    rd(8'h02);
    chk(fb & 8'h10, 8'h00);
    // Released pin reads high; high-active polarity then means a card.
    pin_drv = 1'b0;
    cyc(250);
    rd(8'h03);
    chk(fb & 8'h10, 8'h10);
    rd(8'h01);
    chk(fb & 8'h10, 8'h10);
    chk({7'h00, present}, 8'h01);
    // Activation: the serial line is forced low in the ramp and released once active.
    ccd_host_model_inst.xfer(8'h05, fb);
    cyc(2);
    chk({5'h00, supply_en, card_rst, card_oe}, 8'h05);
    cyc(RAMP + 10);
    chk({6'h00, supply_en, card_oe}, 8'h02);
    // Feedback while active: presence in bit four, active in bit zero.
    rd(8'h05);
    chk(fb, 8'h11);
    // Relay in both directions while active.
    host_low = 1'b1;
    cyc(6);
    chk({6'h00, host_io_oe, card_oe}, 8'h01);
    chk({6'h00, card_io_o, host_io_o}, 8'h00);
    host_low = 1'b0;
    cyc(6);
    card_low = 1'b1;
    cyc(6);
    chk({6'h00, host_io_oe, card_oe}, 8'h02);
    card_low = 1'b0;
    cyc(6);
    chk({6'h00, host_io_oe, card_oe}, 8'h00);
    // Host reset passes only while the unit is selected.
    host_rst = 1'b1;
    cyc(8);
    chk({7'h00, card_rst}, 8'h00);
    ccd_host_model_inst.select(1'b0);
    cyc(8);
    chk({7'h00, card_rst}, 8'h01);
    ccd_host_model_inst.select(1'b1);
    host_rst = 1'b0;
    cyc(8);
    chk({7'h00, card_rst}, 8'h01);
    ccd_host_model_inst.select(1'b0);
    cyc(8);
    chk({7'h00, card_rst}, 8'h00);
    host_rst = 1'b1;
    cyc(8);
    ccd_host_model_inst.select(1'b1);
    // Deactivation pulls the card reset and the serial line low.
    ccd_host_model_inst.xfer(8'h01, fb);
    cyc(4);
    chk({5'h00, supply_en, card_rst, card_oe}, 8'h01);
    // Removal in mid-session also ends the session.
    ccd_host_model_inst.xfer(8'h05, fb);
    cyc(RAMP + 10);
    chk({7'h00, supply_en}, 8'h01);
    pin_drv = 1'b1;
    pin_val = 1'b0;
    cyc(250);
    chk({5'h00, supply_en, card_rst, card_oe}, 8'h01);
    complete_run();
  end
endmodule : ccd_top_tb_top
